//--- design/lt_coef_pkg.sv
/*
 * lt_coef_pkg: shared types and constants for the link training
 * coefficient update handler.
 * Assumes the far end uses the same command and status field encodings.
 */
package lt_coef_pkg;

   // tap indexing
   localparam int NTAP     = 3;
   localparam int TAP_PRE  = 0;
   localparam int TAP_MAIN = 1;
   localparam int TAP_POST = 2;
   localparam int TAP_W    = 6;
   localparam int DELTA_W  = 8;
   localparam int SUM_W    = 9;

   typedef logic [TAP_W-1:0]             tap_t;
   typedef logic signed [DELTA_W-1:0]    delta_t;
   typedef logic signed [SUM_W-1:0]      sum_t;
   typedef logic [NTAP-1:0][TAP_W-1:0]   tap_vec_t;
   typedef logic [NTAP-1:0][1:0]         fld_vec_t;

   // per-tap update request field
   localparam logic [1:0] UPD_HOLD = 2'h0;
   localparam logic [1:0] UPD_INC  = 2'h1;
   localparam logic [1:0] UPD_DEC  = 2'h2;

   // high half of a command
   localparam int HI_INIT   = 0;
   localparam int HI_PRESET = 1;

   // per-tap status field
   localparam logic [1:0] STS_NOT = 2'h0;
   localparam logic [1:0] STS_UPD = 2'h1;
   localparam logic [1:0] STS_MIN = 2'h2;
   localparam logic [1:0] STS_MAX = 2'h3;

   // tap limits and step sizes, index order post/main/pre
   localparam tap_vec_t TAP_MAX  = {6'h20, 6'h3F, 6'h20};
   localparam tap_t     TAP_MIN  = 6'h00;
   localparam tap_vec_t TAP_RST  = {6'h00, 6'h3F, 6'h00};
   localparam tap_t     PRESET_OUTER = 6'h00;
   localparam delta_t   STEP_OUTER   = 8'sh02;
   localparam delta_t   STEP_MAIN    = 8'sh01;
   localparam delta_t   MAIN_COUPLE  = 8'sh01;
   localparam delta_t   DELTA_ZERO   = 8'sh00;

   typedef struct packed {
      logic       vld;
      logic [1:0] hi;
      fld_vec_t   lo;
   } coef_cmd_s;

   typedef struct packed {
      logic     vld;
      fld_vec_t tap;
   } coef_sts_s;

endpackage

//--- design/lt_coef_update.sv
/*
 * lt_coef_update: applies tap commands from the link partner to the local
 * transmit equalizer, answers each with a status report, and issues local
 * commands toward the partner while collecting its replies.
 * Assumes all inputs are synchronous to core_clk and commands are
 * one-cycle valid pulses.
 */
`timescale 1ns/10ps

module lt_coef_update
   import lt_coef_pkg::*;
(
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   // commands from partner and reply
   input  wire lt_coef_pkg::coef_cmd_s cmd_from_rmt,
   output      lt_coef_pkg::coef_sts_s sts_to_rmt,
   // equalizer start values and current taps
   input  wire lt_coef_pkg::tap_vec_t  init_coef,
   output      lt_coef_pkg::tap_vec_t  tx_coef,
   // local command requests
   input  wire lt_coef_pkg::coef_cmd_s lcl_req,
   output      logic                   lcl_req_busy,
   // commands to partner and its replies
   output      lt_coef_pkg::coef_cmd_s upd_to_rmt,
   input  wire lt_coef_pkg::coef_sts_s sts_from_rmt,
   output      lt_coef_pkg::coef_sts_s sts_rcvd
);
   import lt_coef_pkg::*;

   tap_vec_t  tap_ff;
   tap_vec_t  nxt_tap;
   coef_sts_s sts_ff;
   coef_sts_s nxt_sts;
   coef_cmd_s upd_ff;
   logic      busy_ff;
   coef_sts_s rcvd_ff;

   delta_t   own_d [NTAP];
   delta_t   tot_d [NTAP];
   delta_t   couple_d;
   tap_vec_t sat_tap;
   fld_vec_t step_sts;
   fld_vec_t load_sts;
   logic     do_preset;
   logic     do_init;
   tap_vec_t load_tap;

   assign do_preset = cmd_from_rmt.hi[HI_PRESET];
   assign do_init   = cmd_from_rmt.hi[HI_INIT];

   // main tap moves opposite to outer tap direction
   always_comb begin
      couple_d = DELTA_ZERO;
      if (cmd_from_rmt.lo[TAP_PRE] == UPD_INC) begin
         couple_d = couple_d - MAIN_COUPLE;
      end else if (cmd_from_rmt.lo[TAP_PRE] == UPD_DEC) begin
         couple_d = couple_d + MAIN_COUPLE;
      end
      if (cmd_from_rmt.lo[TAP_POST] == UPD_INC) begin
         couple_d = couple_d - MAIN_COUPLE;
      end else if (cmd_from_rmt.lo[TAP_POST] == UPD_DEC) begin
         couple_d = couple_d + MAIN_COUPLE;
      end
   end

   // per-tap step, saturation and status
   genvar gi;
   generate
      for (gi = 0; gi < NTAP; gi++) begin : g_tap
         delta_t step;
         sum_t   sum;
         assign step = (gi == TAP_MAIN) ? STEP_MAIN : STEP_OUTER;
         // hold gives zero delta
         always_comb begin
            if (cmd_from_rmt.lo[gi] == UPD_INC) begin
               own_d[gi] = step;
            end else if (cmd_from_rmt.lo[gi] == UPD_DEC) begin
               own_d[gi] = DELTA_ZERO - step;
            end else begin
               own_d[gi] = DELTA_ZERO;
            end
         end
         assign tot_d[gi] = (gi == TAP_MAIN) ? delta_t'(own_d[gi] + couple_d) : own_d[gi];
         assign sum = $signed({3'h0, tap_ff[gi]}) + $signed({tot_d[gi][DELTA_W-1], tot_d[gi]});
         // clamp instead of wrapping
         always_comb begin
            if (sum < $signed({3'h0, TAP_MIN})) begin
               sat_tap[gi] = TAP_MIN;
            end else if (sum > $signed({3'h0, TAP_MAX[gi]})) begin
               sat_tap[gi] = TAP_MAX[gi];
            end else begin
               sat_tap[gi] = sum[TAP_W-1:0];
            end
         end
         always_comb begin
            if (tot_d[gi] == DELTA_ZERO) begin
               step_sts[gi] = STS_NOT;
            end else if (tot_d[gi] > DELTA_ZERO && sat_tap[gi] == TAP_MAX[gi]) begin
               step_sts[gi] = STS_MAX;
            end else if (tot_d[gi] < DELTA_ZERO && sat_tap[gi] == TAP_MIN) begin
               step_sts[gi] = STS_MIN;
            end else if (sat_tap[gi] != tap_ff[gi]) begin
               step_sts[gi] = STS_UPD;
            end else begin
               step_sts[gi] = STS_NOT;
            end
         end
         // preset and initialize targets
         always_comb begin
            if (do_preset) begin
               load_tap[gi] = (gi == TAP_MAIN) ? TAP_MAX[gi] : PRESET_OUTER;
            end else begin
               load_tap[gi] = init_coef[gi];
            end
         end
         assign load_sts[gi] = (load_tap[gi] != tap_ff[gi]) ? STS_UPD : STS_NOT;
      end
   endgenerate

   // choose next taps and reply; preset wins over initialize
   always_comb begin
      nxt_tap     = tap_ff;
      nxt_sts     = '0;
      nxt_sts.vld = cmd_from_rmt.vld;
      if (cmd_from_rmt.vld) begin
         if (do_preset || do_init) begin
            nxt_tap     = load_tap;
            nxt_sts.tap = load_sts;
         end else begin
            nxt_tap     = sat_tap;
            nxt_sts.tap = step_sts;
         end
      end
   end

   // equalizer taps
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tap_ff <= TAP_RST;
      end else begin
         tap_ff <= nxt_tap;
      end
   end

   // status reply toward partner
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sts_ff <= '0;
      end else begin
         sts_ff <= nxt_sts;
      end
   end

   // outgoing commands, one outstanding at a time
   always_ff @(posedge core_clk) begin
      if (rst) begin
         upd_ff  <= '0;
         busy_ff <= 1'h0;
      end else begin
         upd_ff.vld <= 1'h0;
         if (lcl_req.vld && !busy_ff) begin
            upd_ff  <= lcl_req;
            busy_ff <= 1'h1;
         end else if (busy_ff && sts_from_rmt.vld) begin
            busy_ff <= 1'h0;
         end
      end
   end

   // replies from partner; unsolicited ones dropped
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rcvd_ff <= '0;
      end else begin
         rcvd_ff.vld <= 1'h0;
         if (busy_ff && sts_from_rmt.vld) begin
            rcvd_ff <= sts_from_rmt;
         end
      end
   end

   assign tx_coef      = tap_ff;
   assign sts_to_rmt   = sts_ff;
   assign upd_to_rmt   = upd_ff;
   assign lcl_req_busy = busy_ff;
   assign sts_rcvd     = rcvd_ff;

endmodule

//--- tb/lt_coef_update_properties.sv
/* port checker for lt_coef_update
   bound to every instance, sees only its ports */
`timescale 1ns/10ps
module lt_coef_update_properties
   import lt_coef_pkg::*;
(
   // watched ports
   input wire logic                   core_clk,
   input wire logic                   rst,
   input wire lt_coef_pkg::coef_cmd_s cmd_from_rmt,
   input wire lt_coef_pkg::coef_sts_s sts_to_rmt,
   input wire lt_coef_pkg::tap_vec_t  init_coef,
   input wire lt_coef_pkg::tap_vec_t  tx_coef,
   input wire lt_coef_pkg::coef_cmd_s lcl_req,
   input wire logic                   lcl_req_busy,
   input wire lt_coef_pkg::coef_cmd_s upd_to_rmt,
   input wire lt_coef_pkg::coef_sts_s sts_from_rmt,
   input wire lt_coef_pkg::coef_sts_s sts_rcvd
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   wire logic       plain = cmd_from_rmt.vld && cmd_from_rmt.hi == 2'h0;
   wire logic [5:0] lo    = cmd_from_rmt.lo;
   sequence s_take;
      lcl_req.vld && !lcl_req_busy;
   endsequence
   sequence s_reply;
      lcl_req_busy && sts_from_rmt.vld;
   endsequence
   a_reply_per_cmd: assert property (
      1 |=> sts_to_rmt.vld == $past(cmd_from_rmt.vld))
      else $error("reply pulse mismatch");
   a_preset_taps: assert property (
      cmd_from_rmt.vld && cmd_from_rmt.hi[HI_PRESET] |=> tx_coef == 18'h00FC0)
      else $error("preset taps wrong");
   a_main_inc_only: assert property (
      plain && lo == 6'h04 && tx_coef[1] < 6'h3F |=> tx_coef == $past(tx_coef) + 18'h40)
      else $error("main increment wrong");
   a_post_dec_pair: assert property (
      plain && lo == 6'h20 && tx_coef[2] > 6'h01 && tx_coef[1] < 6'h3F
      |=> tx_coef == $past(tx_coef) - 18'h01FC0)
      else $error("post decrement wrong");
   a_main_sat_max: assert property (
      plain && lo == 6'h04 && tx_coef[1] == 6'h3F
      |=> tx_coef[1] == 6'h3F && sts_to_rmt.tap[1] == STS_MAX)
      else $error("main saturation wrong");
   a_pre_dec_min: assert property (
      plain && lo == 6'h02 && tx_coef[0] < 6'h03
      |=> tx_coef[0] == 6'h00 && sts_to_rmt.tap[0] == STS_MIN)
      else $error("pre minimum wrong");
   a_issue_local: assert property (
      s_take |=> upd_to_rmt.vld && lcl_req_busy && upd_to_rmt.lo == $past(lcl_req.lo))
      else $error("local command not issued");
   a_reply_capture: assert property (
      s_reply |=> sts_rcvd.vld && !lcl_req_busy && sts_rcvd.tap == $past(sts_from_rmt.tap))
      else $error("partner reply not captured");
endmodule
bind lt_coef_update lt_coef_update_properties u_props (.*);

//--- tb/lt_rmt_model.sv
/* partner training logic: answers each command lat+1 cycles after it
   assumes lat is at least one */
`timescale 1ns/10ps
module lt_rmt_model
   import lt_coef_pkg::*;
(
   // partner side
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic [7:0]             lat,
   input  wire lt_coef_pkg::coef_cmd_s upd_to_rmt,
   output      lt_coef_pkg::coef_sts_s sts_from_rmt
);
   logic [7:0] cnt_ff;
   always_ff @(posedge core_clk) begin
      if (rst) cnt_ff <= 8'h00;
      else if (upd_to_rmt.vld) cnt_ff <= lat;
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
   end
   // one reply per command, fields scrambled when idle
   always_ff @(posedge core_clk) begin
      sts_from_rmt.vld <= !rst && cnt_ff == 8'h01;
      sts_from_rmt.tap <= (cnt_ff == 8'h01) ? upd_to_rmt.lo : ~sts_from_rmt.tap;
   end
endmodule

//--- tb/tb_lt_coefficient_update_handler.sv
/* bench for lt_coef_update with a partner model
   assumes the checker and partner model compile first */
`timescale 1ns/10ps
module tb_lt_coefficient_update_handler;
   import lt_coef_pkg::*;
   logic       core_clk     = 0;
   logic       rst          = 1;
   logic [7:0] lat          = 8'h01;
   coef_cmd_s  cmd_from_rmt = '0;
   coef_cmd_s  lcl_req      = '0;
   tap_vec_t   init_coef    = {6'h04, 6'h30, 6'h08};
   coef_sts_s  sts_to_rmt;
   coef_sts_s  sts_from_rmt;
   coef_sts_s  sts_rcvd;
   coef_cmd_s  upd_to_rmt;
   tap_vec_t   tx_coef;
   logic       lcl_req_busy;
   int         n_mismatch   = 0;
   int         n_compared   = 0;
   int         cyc          = 0;
   lt_coef_update u_dut (.*);
   lt_rmt_model u_rmt (.*);
   always #2.5 core_clk = ~core_clk;
   task chk(input logic [17:0] got, input logic [17:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("mismatches %0d, compares %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task step(input logic [1:0] hi, input logic [5:0] lo, input tap_vec_t et, input logic [5:0] es);
      @(posedge core_clk) #1;
      cmd_from_rmt = {1'b1, hi, lo};
      @(posedge core_clk) #1;
      cmd_from_rmt.vld = 0;
      chk(tx_coef, et);
      chk(18'({sts_to_rmt.vld, sts_to_rmt.tap}), 18'({1'h1, es}));
   endtask
   task t_steps;
      step(2'h0, 6'h01, {6'h00, 6'h3E, 6'h02}, 6'h05);
      step(2'h0, 6'h10, {6'h02, 6'h3D, 6'h02}, 6'h14);
      step(2'h0, 6'h08, {6'h02, 6'h3C, 6'h02}, 6'h04);
      step(2'h0, 6'h04, {6'h02, 6'h3D, 6'h02}, 6'h04);
      step(2'h0, 6'h02, {6'h02, 6'h3E, 6'h00}, 6'h06);
      step(2'h0, 6'h20, {6'h00, 6'h3F, 6'h00}, 6'h2C);
      step(2'h0, 6'h00, {6'h00, 6'h3F, 6'h00}, 6'h00);
      step(2'h0, 6'h04, {6'h00, 6'h3F, 6'h00}, 6'h0C);
   endtask
   task t_presets;
      step(2'h1, 6'h00, init_coef, 6'h15);
      step(2'h2, 6'h00, {6'h00, 6'h3F, 6'h00}, 6'h15);
      step(2'h3, 6'h10, {6'h00, 6'h3F, 6'h00}, 6'h00);
   endtask
   task t_local(input logic [7:0] l, input logic [5:0] lo);
      int n;
      lat = l;
      @(posedge core_clk) #1;
      lcl_req = {1'b1, 2'h0, lo};
      @(posedge core_clk) #1;
      lcl_req.lo = ~lo;
      chk(18'({upd_to_rmt.vld, upd_to_rmt.lo, lcl_req_busy}), 18'({1'h1, lo, 1'h1}));
      @(posedge core_clk) #1;
      lcl_req.vld = 0;
      chk(18'(upd_to_rmt.vld), 18'h0);
      n = 0;
      while (sts_rcvd.vld !== 1'b1 && n < 20) begin
         @(posedge core_clk) #1;
         n++;
      end
      chk(18'({sts_rcvd.vld, sts_rcvd.tap, lcl_req_busy}), 18'({1'h1, lo, 1'h0}));
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      #1;
      rst = 0;
      t_steps();
      t_presets();
      t_local(8'h01, 6'h29);
      t_local(8'h06, 6'h16);
      finish_test();
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         finish_test();
      end
   end
endmodule
